// File: csr_bank.v
// Purpose: System register bank of a 32-bit core with its data formatter
// Assumes: All inputs synchronous to core_clk; events are one-cycle pulses
// Notes: Hardware saves win over an instruction write in the same cycle
//
// Overview of operation
// - System registers are reached only by the register load and store instructions, selected by number.
// - Taking an exception or maskable interrupt saves PC and status word into the exception save pair.
// - A non-maskable interrupt or duplexed exception saves PC and status word into the fatal save pair.
// - Every cause is recorded, fatal codes in the upper half and exception codes in the lower half.
// - Register 5 holds the program status word of processor and result flags.
// - Register 6 is read-only and returns the processor type identification.
// - Register 7 holds the task control word that governs floating-point operation.
// - Register 24 holds the control word of the instruction cache.
// - A match of the trap register with the PC redirects to a fixed handler address.
// - Data is little-endian, byte A in bits 7 to 0 and byte A + 3 in bits 31 to 24.
// - Signed integers of 8, 16 and 32 bits are two's complement with the top bit as sign.
// - Unsigned integers use every bit as magnitude.
// - Bit 0 of every saved or restored PC is held at zero.
`timescale 1ns/10ps
`include "csr_bank_regs.vh"

module csr_bank #(
  parameter DATA_W = 32,
  // Arbitrary value, stands in for the real type number
  parameter [31:0] PROC_ID = 32'h0000_1234,
  parameter [31:0] TRAP_HANDLER = 32'h0000_0100,
  parameter [31:0] PSW_RESET = 32'h0000_0000
) (
  input wire core_clk,
  input wire reset_n,
  input wire sys_reg_load,
  input wire sys_reg_store,
  input wire [4:0] sys_reg_num,
  input wire [31:0] sys_reg_wdata,
  input wire exc_take,
  input wire [15:0] exc_code,
  input wire fatal_take,
  input wire [15:0] fatal_code,
  input wire [31:0] cur_pc,
  input wire pc_valid,
  input wire psw_update,
  input wire [31:0] psw_next,
  input wire mem_fmt_req,
  input wire [31:0] mem_addr,
  input wire [1:0] mem_size,
  input wire mem_signed,
  input wire [31:0] mem_rword,
  input wire [31:0] mem_wdatum,
  output reg [31:0] sys_reg_rdata_q,
  output reg sys_reg_rvalid_q,
  output reg [31:0] exception_saved_pc_q,
  output reg [31:0] exception_saved_status_q,
  output reg [31:0] fatal_saved_pc_q,
  output reg [31:0] fatal_saved_status_q,
  output reg [31:0] program_status_word_q,
  output reg [31:0] float_task_control_q,
  output reg [31:0] icache_control_q,
  output reg trap_hit_q,
  output reg [31:0] trap_target_q,
  output reg [31:0] mem_ld_value_q,
  output reg [31:0] mem_st_lanes_q,
  output reg [3:0] mem_st_be_q,
  output reg [31:0] mem_addr_q,
  output reg mem_misaligned_q,
  output reg mem_fmt_valid_q
);

  reg [15:0] fatal_cause_code_q;
  reg [15:0] interrupt_cause_code_q;
  reg [31:0] pc_trap_address_q;
  reg [31:0] rdata_d;
  reg wr_exc_pc;
  reg wr_exc_psw;
  reg wr_fat_pc;
  reg wr_fat_psw;
  reg wr_psw;
  reg wr_ftc;
  reg wr_icc;
  reg wr_trap;
  reg trap_armed_q;
  reg [31:0] exc_pc_d;
  reg [31:0] exc_psw_d;
  reg [31:0] fat_pc_d;
  reg [31:0] fat_psw_d;
  reg [15:0] fat_code_d;
  reg [15:0] exc_code_d;
  reg [31:0] psw_d;
  wire [31:0] pc_even;
  wire [31:0] wdata_even;
  wire trap_match;
  wire [31:0] fmt_ld_value;
  wire [31:0] fmt_st_lanes;
  wire [3:0] fmt_st_be;
  wire fmt_misaligned;

  assign pc_even = cur_pc & `CSR_PC_ALIGN_MASK;
  assign wdata_even = sys_reg_wdata & `CSR_PC_ALIGN_MASK;

  // Write decode; numbers with no register and read-only ones fall through
  always @* begin
    wr_exc_pc = 1'b0;
    wr_exc_psw = 1'b0;
    wr_fat_pc = 1'b0;
    wr_fat_psw = 1'b0;
    wr_psw = 1'b0;
    wr_ftc = 1'b0;
    wr_icc = 1'b0;
    wr_trap = 1'b0;
    if (!sys_reg_load) begin
      wr_exc_pc = 1'b0;
    end else if (sys_reg_num == `CSR_NUM_EXC_PC) begin
      wr_exc_pc = 1'b1;
    end else if (sys_reg_num == `CSR_NUM_EXC_PSW) begin
      wr_exc_psw = 1'b1;
    end else if (sys_reg_num == `CSR_NUM_FAT_PC) begin
      wr_fat_pc = 1'b1;
    end else if (sys_reg_num == `CSR_NUM_FAT_PSW) begin
      wr_fat_psw = 1'b1;
    end else if (sys_reg_num == `CSR_NUM_PSW) begin
      wr_psw = 1'b1;
    end else if (sys_reg_num == `CSR_NUM_FTC) begin
      wr_ftc = 1'b1;
    end else if (sys_reg_num == `CSR_NUM_ICC) begin
      wr_icc = 1'b1;
    end else if (sys_reg_num == `CSR_NUM_TRAP) begin
      wr_trap = 1'b1;
    end else begin
      wr_exc_pc = 1'b0;
    end
  end

  // Read decode
  always @* begin
    if (sys_reg_num == `CSR_NUM_EXC_PC) begin
      rdata_d = exception_saved_pc_q;
    end else if (sys_reg_num == `CSR_NUM_EXC_PSW) begin
      rdata_d = exception_saved_status_q;
    end else if (sys_reg_num == `CSR_NUM_FAT_PC) begin
      rdata_d = fatal_saved_pc_q;
    end else if (sys_reg_num == `CSR_NUM_FAT_PSW) begin
      rdata_d = fatal_saved_status_q;
    end else if (sys_reg_num == `CSR_NUM_CAUSE) begin
      rdata_d = {fatal_cause_code_q, interrupt_cause_code_q};
    end else if (sys_reg_num == `CSR_NUM_PSW) begin
      rdata_d = program_status_word_q;
    end else if (sys_reg_num == `CSR_NUM_PID) begin
      rdata_d = PROC_ID;
    end else if (sys_reg_num == `CSR_NUM_FTC) begin
      rdata_d = float_task_control_q;
    end else if (sys_reg_num == `CSR_NUM_ICC) begin
      rdata_d = icache_control_q;
    end else if (sys_reg_num == `CSR_NUM_TRAP) begin
      rdata_d = pc_trap_address_q;
    end else begin
      rdata_d = `CSR_RST_WORD;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_reg_rdata_q <= `CSR_RST_WORD;
      sys_reg_rvalid_q <= 1'b0;
    end else begin
      sys_reg_rvalid_q <= sys_reg_store;
      if (sys_reg_store) begin
        sys_reg_rdata_q <= rdata_d;
      end
    end
  end

  // Exception save pair; one pair only, a later event overwrites it
  always @* begin
    exc_pc_d = exception_saved_pc_q;
    exc_psw_d = exception_saved_status_q;
    if (exc_take) begin
      exc_pc_d = pc_even;
      exc_psw_d = program_status_word_q;
    end else begin
      if (wr_exc_pc) begin
        exc_pc_d = wdata_even;
      end
      if (wr_exc_psw) begin
        exc_psw_d = sys_reg_wdata;
      end
    end
  end

  // Fatal save pair
  always @* begin
    fat_pc_d = fatal_saved_pc_q;
    fat_psw_d = fatal_saved_status_q;
    if (fatal_take) begin
      fat_pc_d = pc_even;
      fat_psw_d = program_status_word_q;
    end else begin
      if (wr_fat_pc) begin
        fat_pc_d = wdata_even;
      end
      if (wr_fat_psw) begin
        fat_psw_d = sys_reg_wdata;
      end
    end
  end

  // Both pairs take the status word as held before the event edge
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      exception_saved_pc_q <= `CSR_RST_WORD;
      exception_saved_status_q <= `CSR_RST_WORD;
      fatal_saved_pc_q <= `CSR_RST_WORD;
      fatal_saved_status_q <= `CSR_RST_WORD;
    end else begin
      exception_saved_pc_q <= exc_pc_d;
      exception_saved_status_q <= exc_psw_d;
      fatal_saved_pc_q <= fat_pc_d;
      fatal_saved_status_q <= fat_psw_d;
    end
  end

  // Cause register halves update independently, so a fatal event
  // does not erase the code of the exception it interrupted
  always @* begin
    fat_code_d = fatal_cause_code_q;
    exc_code_d = interrupt_cause_code_q;
    if (fatal_take) begin
      fat_code_d = fatal_code;
    end
    if (exc_take) begin
      exc_code_d = exc_code;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fatal_cause_code_q <= `CSR_RST_CODE;
      interrupt_cause_code_q <= `CSR_RST_CODE;
    end else begin
      fatal_cause_code_q <= fat_code_d;
      interrupt_cause_code_q <= exc_code_d;
    end
  end

  // Core flag updates win over an instruction write in the same cycle
  always @* begin
    psw_d = program_status_word_q;
    if (psw_update) begin
      psw_d = psw_next;
    end else if (wr_psw) begin
      psw_d = sys_reg_wdata;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      program_status_word_q <= PSW_RESET;
    end else begin
      program_status_word_q <= psw_d;
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      float_task_control_q <= `CSR_RST_WORD;
      icache_control_q <= `CSR_RST_WORD;
      pc_trap_address_q <= `CSR_RST_WORD;
    end else begin
      if (wr_ftc) begin
        float_task_control_q <= sys_reg_wdata;
      end
      if (wr_icc) begin
        icache_control_q <= sys_reg_wdata;
      end
      if (wr_trap) begin
        pc_trap_address_q <= wdata_even;
      end
    end
  end

  // Trap compare; fires once per arrival so the handler is not
  // retriggered while the same PC is still presented
  assign trap_match = pc_valid && (pc_even == pc_trap_address_q);

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trap_hit_q <= 1'b0;
      trap_armed_q <= 1'b1;
      trap_target_q <= `CSR_RST_WORD;
    end else begin
      trap_hit_q <= trap_match && trap_armed_q;
      trap_target_q <= TRAP_HANDLER;
      if (wr_trap) begin
        trap_armed_q <= 1'b1;
      end else if (pc_valid) begin
        trap_armed_q <= !trap_match;
      end
    end
  end

  // Memory data formatting for loads and stores
  csr_data_fmt #(
    .DATA_W(DATA_W)
  ) u_fmt (
    .addr_lo(mem_addr[1:0]),
    .size(mem_size),
    .sign_ext(mem_signed),
    .ld_word(mem_rword),
    .st_datum(mem_wdatum),
    .ld_value(fmt_ld_value),
    .st_lanes(fmt_st_lanes),
    .st_be(fmt_st_be),
    .misaligned(fmt_misaligned)
  );

  // Misaligned low bits are forced to zero instead of faulting
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ld_value_q <= `CSR_RST_WORD;
      mem_st_lanes_q <= `CSR_RST_WORD;
      mem_st_be_q <= `CSR_BE_NONE;
      mem_addr_q <= `CSR_RST_WORD;
      mem_misaligned_q <= 1'b0;
      mem_fmt_valid_q <= 1'b0;
    end else begin
      mem_fmt_valid_q <= mem_fmt_req;
      if (mem_fmt_req) begin
        mem_ld_value_q <= fmt_ld_value;
        mem_st_lanes_q <= fmt_st_lanes;
        mem_st_be_q <= fmt_st_be;
        mem_misaligned_q <= fmt_misaligned;
        if (mem_size == `CSR_SZ_BYTE) begin
          mem_addr_q <= mem_addr;
        end else if (mem_size == `CSR_SZ_HALF) begin
          mem_addr_q <= {mem_addr[31:1], 1'b0};
        end else begin
          mem_addr_q <= {mem_addr[31:2], 2'b00};
        end
      end
    end
  end

endmodule

// File: csr_bank_monitor.sv
// Purpose: Port checker for the system register bank
// Assumes: One clock domain, reset_n asynchronous active low
// Notes: Bound to every csr_bank instance
`timescale 1ns/10ps
module csr_bank_monitor #(
  parameter [31:0] PROC_ID = 32'h0000_1234,
  parameter [31:0] TRAP_HANDLER = 32'h0000_0100
) (
  input wire core_clk,
  input wire reset_n,
  input wire sys_reg_load,
  input wire sys_reg_store,
  input wire [4:0] sys_reg_num,
  input wire [31:0] sys_reg_wdata,
  input wire exc_take,
  input wire fatal_take,
  input wire [31:0] cur_pc,
  input wire psw_update,
  input wire [31:0] psw_next,
  input wire mem_fmt_req,
  input wire [31:0] mem_addr,
  input wire [1:0] mem_size,
  input wire [31:0] sys_reg_rdata_q,
  input wire sys_reg_rvalid_q,
  input wire [31:0] exception_saved_pc_q,
  input wire [31:0] exception_saved_status_q,
  input wire [31:0] fatal_saved_pc_q,
  input wire [31:0] fatal_saved_status_q,
  input wire [31:0] program_status_word_q,
  input wire [31:0] float_task_control_q,
  input wire trap_hit_q,
  input wire [31:0] trap_target_q,
  input wire [3:0] mem_st_be_q,
  input wire mem_misaligned_q
);
  wire mis_w = (mem_size == 2'h1 && mem_addr[0]) ||
    (mem_size == 2'h2 && mem_addr[1:0] != 2'h0);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence ftc_wr_s;
    sys_reg_load && sys_reg_num == 5'h07;
  endsequence
  sequence rsvd_rd_s;
    sys_reg_store && sys_reg_num inside {[5'h08:5'h17], [5'h1a:5'h1f]};
  endsequence
  sequence byte_fmt_s;
    mem_fmt_req && mem_size == 2'h0;
  endsequence
  exc_save_a: assert property (exc_take |=>
    exception_saved_pc_q == ($past(cur_pc) & 32'hffff_fffe) &&
    exception_saved_status_q == $past(program_status_word_q))
    else $error("exception save pair wrong");
  fatal_save_a: assert property (fatal_take |=>
    fatal_saved_pc_q == ($past(cur_pc) & 32'hffff_fffe) &&
    fatal_saved_status_q == $past(program_status_word_q))
    else $error("fatal save pair wrong");
  read_valid_a: assert property (
    sys_reg_rvalid_q == $past(sys_reg_store))
    else $error("read valid not one cycle after store");
  psw_load_a: assert property (
    psw_update |=> program_status_word_q == $past(psw_next))
    else $error("status word update lost");
  ftc_write_a: assert property (
    ftc_wr_s |=> float_task_control_q == $past(sys_reg_wdata))
    else $error("task control write lost");
  rsvd_zero_a: assert property (
    rsvd_rd_s |=> sys_reg_rdata_q == 32'h0000_0000)
    else $error("reserved number read not zero");
  pid_read_a: assert property (
    sys_reg_store && sys_reg_num == 5'h06 |=> sys_reg_rdata_q == PROC_ID)
    else $error("identity read wrong");
  trap_target_a: assert property (
    trap_hit_q |-> trap_target_q == TRAP_HANDLER)
    else $error("trap target wrong");
  trap_single_a: assert property (
    trap_hit_q && !$past(sys_reg_load && sys_reg_num == 5'h19) |=>
    !trap_hit_q)
    else $error("trap hit repeated");
  byte_lane_a: assert property (byte_fmt_s |=>
    mem_st_be_q == (4'h1 << ($past(mem_addr) & 32'h3)))
    else $error("byte lane enable wrong");
  misalign_a: assert property (
    mem_fmt_req |=> mem_misaligned_q == $past(mis_w))
    else $error("misaligned flag wrong");
endmodule
bind csr_bank csr_bank_monitor #(.PROC_ID(PROC_ID),
  .TRAP_HANDLER(TRAP_HANDLER)) mon (.*);

// File: csr_bank_regs.vh
// Purpose: Constants for the system register bank and data formatting
// Assumes: Included by csr_bank.v and csr_data_fmt.v
// Notes: Register numbers are 5-bit system register indices
`ifndef CSR_BANK_REGS_VH
`define CSR_BANK_REGS_VH

`define CSR_NUM_W 5
`define CSR_DATA_W 32
`define CSR_CODE_W 16

// System register numbers
`define CSR_NUM_EXC_PC 5'h00
`define CSR_NUM_EXC_PSW 5'h01
`define CSR_NUM_FAT_PC 5'h02
`define CSR_NUM_FAT_PSW 5'h03
`define CSR_NUM_CAUSE 5'h04
`define CSR_NUM_PSW 5'h05
`define CSR_NUM_PID 5'h06
`define CSR_NUM_FTC 5'h07
`define CSR_NUM_ICC 5'h18
`define CSR_NUM_TRAP 5'h19

// Cause register field layout
`define CSR_CAUSE_FAT_HI 31
`define CSR_CAUSE_FAT_LO 16
`define CSR_CAUSE_EXC_HI 15
`define CSR_CAUSE_EXC_LO 0

// Reset values and PC alignment mask
`define CSR_RST_WORD 32'h0000_0000
`define CSR_RST_CODE 16'h0000
`define CSR_PC_ALIGN_MASK 32'hffff_fffe

// Access sizes
`define CSR_SZ_BYTE 2'h0
`define CSR_SZ_HALF 2'h1
`define CSR_SZ_WORD 2'h2

// Byte enables and lane layout
`define CSR_BE_NONE 4'h0
`define CSR_BE_B0 4'h1
`define CSR_BE_H0 4'h3
`define CSR_BE_ALL 4'hf
`define CSR_BYTE_W 8
`define CSR_HALF_W 16

`endif

// File: csr_core_model.sv
// Purpose: Core side model: exception events, PC feed, status updates
// Assumes: Tasks are called just after a rising edge of core_clk
// Notes: Drives each event for exactly one cycle
`timescale 1ns/10ps
module csr_core_model (
  input wire core_clk,
  output reg exc_take,
  output reg [15:0] exc_code,
  output reg fatal_take,
  output reg [15:0] fatal_code,
  output reg [31:0] cur_pc,
  output reg pc_valid,
  output reg psw_update,
  output reg [31:0] psw_next
);
  initial begin
    exc_take = 1'b0;
    fatal_take = 1'b0;
    exc_code = 16'h0000;
    fatal_code = 16'h0000;
    cur_pc = 32'h0000_0000;
    pc_valid = 1'b0;
    psw_update = 1'b0;
    psw_next = 32'h0000_0000;
  end
  task psw_set(input [31:0] v);
    begin
      psw_update = 1'b1;
      psw_next = v;
      @(posedge core_clk);
      #1;
      psw_update = 1'b0;
      psw_next = ~v;
    end
  endtask
  // Never nests: the bench reads the pair back before the next event
  task event_take(input fatal, input [31:0] pc, input [15:0] code);
    begin
      exc_take = !fatal;
      fatal_take = fatal;
      exc_code = code;
      fatal_code = code;
      cur_pc = pc;
      @(posedge core_clk);
      #1;
      exc_take = 1'b0;
      fatal_take = 1'b0;
      exc_code = ~code;
      fatal_code = ~code;
      cur_pc = ~pc;
    end
  endtask
  task fetch(input v, input [31:0] pc);
    begin
      pc_valid = v;
      cur_pc = pc;
    end
  endtask
endmodule

// File: csr_data_fmt.v
// Purpose: Little-endian lane placement and integer extension for data
// Assumes: Combinational; caller registers the outputs
// Notes: Misaligned addresses are masked down, and flagged
`timescale 1ns/10ps
`include "csr_bank_regs.vh"

module csr_data_fmt #(
  parameter DATA_W = 32
) (
  input wire [1:0] addr_lo,
  input wire [1:0] size,
  input wire sign_ext,
  input wire [DATA_W-1:0] ld_word,
  input wire [DATA_W-1:0] st_datum,
  output reg [DATA_W-1:0] ld_value,
  output reg [DATA_W-1:0] st_lanes,
  output reg [3:0] st_be,
  output reg misaligned
);

  reg [1:0] eff_lo;
  reg [7:0] byte_v;
  reg [15:0] half_v;

  always @* begin
    eff_lo = addr_lo;
    misaligned = 1'b0;
    ld_value = `CSR_RST_WORD;
    st_lanes = `CSR_RST_WORD;
    st_be = `CSR_BE_NONE;
    byte_v = ld_word[8*addr_lo +: `CSR_BYTE_W];
    half_v = 16'h0000;
    case (size)
      `CSR_SZ_BYTE: begin
        // Signed uses the top bit as sign, unsigned as value
        ld_value = {{24{sign_ext & byte_v[7]}}, byte_v};
        st_lanes = {4{st_datum[7:0]}};
        st_be = `CSR_BE_B0 << addr_lo;
      end
      `CSR_SZ_HALF: begin
        misaligned = addr_lo[0];
        eff_lo = {addr_lo[1], 1'b0};
        half_v = ld_word[8*eff_lo +: `CSR_HALF_W];
        ld_value = {{16{sign_ext & half_v[15]}}, half_v};
        st_lanes = {2{st_datum[15:0]}};
        st_be = `CSR_BE_H0 << eff_lo;
      end
      default: begin
        misaligned = |addr_lo;
        ld_value = ld_word;
        st_lanes = st_datum;
        st_be = `CSR_BE_ALL;
      end
    endcase
  end

endmodule

// File: tb_cpu_system_register_bank.sv
// Purpose: Self-checking bench for the system register bank
// Assumes: Inputs driven 1 ns after each rising edge
// Notes: Core side events come from csr_core_model
`timescale 1ns/10ps
module tb_cpu_system_register_bank;
  localparam [31:0] PID = 32'h0000_1234; // Arbitrary value
  localparam [31:0] HANDLER = 32'h0000_0100;
  localparam [39:0] RW_NUMS = {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h07,
    5'h18, 5'h19};
  localparam [29:0] RO_NUMS = {5'h04, 5'h06, 5'h08, 5'h17, 5'h1a, 5'h1f};
  reg core_clk = 1'b0;
  reg reset_n = 1'b0;
  reg sys_reg_load = 1'b0;
  reg sys_reg_store = 1'b0;
  reg [4:0] sys_reg_num = 5'h00;
  reg [31:0] sys_reg_wdata = 32'h0000_0000;
  reg mem_fmt_req = 1'b0;
  reg [31:0] mem_addr = 32'h0000_0000;
  reg [1:0] mem_size = 2'h0;
  reg mem_signed = 1'b0;
  reg [31:0] mem_rword = 32'h817f_c235;
  reg [31:0] mem_wdatum = 32'h1122_33a4;
  wire exc_take, fatal_take, pc_valid, psw_update;
  wire [15:0] exc_code, fatal_code;
  wire [31:0] cur_pc, psw_next, sys_reg_rdata_q, exception_saved_pc_q;
  wire [31:0] exception_saved_status_q, fatal_saved_pc_q, trap_target_q;
  wire [31:0] fatal_saved_status_q, program_status_word_q, mem_addr_q;
  wire [31:0] float_task_control_q, icache_control_q, mem_ld_value_q;
  wire [31:0] mem_st_lanes_q;
  wire sys_reg_rvalid_q, trap_hit_q, mem_misaligned_q, mem_fmt_valid_q;
  wire [3:0] mem_st_be_q;
  integer fails = 0;
  integer checked = 0;
  always #2 core_clk = ~core_clk;
  csr_core_model core (.*);
  csr_bank #(.PROC_ID(PID), .TRAP_HANDLER(HANDLER)) dut (.*);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked++;
      if (got !== exp) begin
        fails++;
        $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task step;
    begin
      @(posedge core_clk);
      #1;
    end
  endtask
  task wr(input [4:0] n, input [31:0] d);
    begin
      sys_reg_load = 1'b1;
      sys_reg_num = n;
      sys_reg_wdata = d;
      step;
      sys_reg_load = 1'b0;
    end
  endtask
  task rd(input [4:0] n, input [31:0] exp);
    begin
      sys_reg_store = 1'b1;
      sys_reg_num = n;
      step;
      sys_reg_store = 1'b0;
      chk({31'h0, sys_reg_rvalid_q}, 32'h1);
      chk(sys_reg_rdata_q, exp);
    end
  endtask
  task fmt(input [31:0] a, input [1:0] s, input sg, input [31:0] ld,
    input [3:0] be, input mis);
    begin
      mem_fmt_req = 1'b1;
      mem_addr = a;
      mem_size = s;
      mem_signed = sg;
      step;
      chk(mem_ld_value_q, ld);
      chk({28'h0, mem_st_be_q}, {28'h0, be});
      chk({31'h0, mem_misaligned_q}, {31'h0, mis});
      chk({31'h0, mem_fmt_valid_q}, 32'h1);
      chk(mem_addr_q, s == 2'h2 ? a & ~32'h3 :
        s == 2'h1 ? a & ~32'h1 : a);
    end
  endtask
  task t_regs;
    integer i;
    reg [4:0] n;
    reg [31:0] d;
    begin
      for (i = 0; i < 8; i++) begin
        n = RW_NUMS[i*5 +: 5];
        d = 32'ha5c3_0f01 ^ {i[7:0], 24'h0};
        wr(n, d);
        if (n == 5'h00 || n == 5'h02 || n == 5'h19) d[0] = 1'b0;
        rd(n, d);
      end
      chk(float_task_control_q, 32'ha7c3_0f01);
      chk(icache_control_q, 32'ha4c3_0f01);
      $display("register read and write test done");
    end
  endtask
  task t_ro;
    integer i;
    reg [4:0] n;
    begin
      for (i = 0; i < 6; i++) begin
        n = RO_NUMS[i*5 +: 5];
        wr(n, 32'hffff_ffff);
        rd(n, n == 5'h06 ? PID : 32'h0000_0000);
      end
      $display("read-only and reserved test done");
    end
  endtask
  task t_exc;
    begin
      core.psw_set(32'h0000_00a5);
      chk(program_status_word_q, 32'h0000_00a5);
      core.event_take(1'b0, 32'h0000_2001, 16'hff90);
      chk(exception_saved_pc_q, 32'h0000_2000);
      chk(exception_saved_status_q, 32'h0000_00a5);
      rd(5'h04, 32'h0000_ff90);
      core.psw_set(32'h0000_5a00);
      core.event_take(1'b1, 32'h0000_4003, 16'h0010);
      chk(fatal_saved_pc_q, 32'h0000_4002);
      chk(fatal_saved_status_q, 32'h0000_5a00);
      rd(5'h03, 32'h0000_5a00);
      // An idle edge keeps the store strobe from dropping and rising at once
      step;
      rd(5'h04, 32'h0010_ff90);
      chk(exception_saved_pc_q, 32'h0000_2000);
      $display("exception save test done");
    end
  endtask
  task t_trap;
    begin
      wr(5'h19, 32'h0000_3001);
      core.fetch(1'b1, 32'h0000_3004);
      step;
      chk({31'h0, trap_hit_q}, 32'h0);
      core.fetch(1'b1, 32'h0000_3001);
      step;
      chk({31'h0, trap_hit_q}, 32'h1);
      chk(trap_target_q, HANDLER);
      step;
      chk({31'h0, trap_hit_q}, 32'h0);
      core.fetch(1'b0, 32'hffff_cffe);
      $display("address trap test done");
    end
  endtask
  task t_fmt;
    integer i;
    reg [7:0] b;
    begin
      for (i = 0; i < 4; i++) begin
        b = mem_rword[i*8 +: 8];
        fmt(32'h1000 + i, 2'h0, 1'b1, {{24{b[7]}}, b},
          4'h1 << i, 1'b0);
        chk(mem_st_lanes_q, {4{8'ha4}});
        fmt(32'h1000 + i, 2'h0, 1'b0, {24'h0, b},
          4'h1 << i, 1'b0);
      end
      fmt(32'h1002, 2'h1, 1'b1, 32'hffff_817f, 4'hc, 0);
      chk(mem_st_lanes_q, {2{16'h33a4}});
      fmt(32'h1003, 2'h1, 1'b0, 32'h0000_817f, 4'hc, 1);
      fmt(32'h1001, 2'h2, 1'b1, 32'h817f_c235, 4'hf, 1);
      fmt(32'h1000, 2'h2, 1'b0, 32'h817f_c235, 4'hf, 0);
      mem_fmt_req = 1'b0;
      $display("data format test done");
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #2000;
    fails++;
    results;
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    t_ro;
    t_regs;
    t_exc;
    t_trap;
    t_fmt;
    results;
  end
endmodule
